// >>> rtl/gst_pkg.sv
// Package with constants and carrier types for the gated sixteen-bit timer.
package gst_pkg;

  // Counter, prescaler and gate geometry.
  localparam int unsigned COUNT_W      = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned PRESCALE_W   = 3;
  localparam int unsigned PS_SEL_W     = 2;
  localparam int unsigned GATE_SEL_W   = 2;
  localparam int unsigned GATE_SRC_N   = 4;

  // Reset values and the all-ones wrap value.
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [2:0]  PS_RESET     = 3'h0;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

  // Clock source selection.
  typedef enum logic {
    GST_SRC_SYS,
    GST_SRC_EXT
  } gst_src_t;

  // Timer control settings.
  typedef struct packed {
    logic              timer_on;
    logic [1:0]        prescale_select;
    logic              secondary_osc_enable;
    logic              sync_disable;
    gst_src_t          clk_src;
  } gst_ctrl_t;

  // Gate control settings.
  typedef struct packed {
    logic              gate_enable;
    logic              gate_polarity;
    logic [1:0]        gate_select;
  } gst_gate_t;

  // Software write to the count pair.
  typedef struct packed {
    logic              wr_low;
    logic              wr_high;
    logic [7:0]        data;
  } gst_wr_t;

endpackage

// >>> rtl/gst_prescaler.sv
// Prescale divider that turns count-clock edges into counter ticks.
`timescale 1ns/1ps
module gst_prescaler (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control.
  input  wire logic [1:0] prescale_select,
  input  wire logic       clear,
  input  wire logic       edge_in,
  // Tick out.
  output logic            tick
);

  logic [2:0] ps_ff;
  logic [2:0] nxt_ps;
  logic [2:0] ps_mask;

  // Mask of prescale bits that must all be set before a tick.
  always_comb begin
    ps_mask = 3'((4'h1 << prescale_select) - 4'h1);
  end

  // Tick when all masked bits are ones on an edge.
  always_comb begin
    tick   = edge_in && ((ps_ff & ps_mask) == ps_mask);
    nxt_ps = 3'(ps_ff + 3'h1);
  end

  // Hidden prescale count; it has no software access path.  // see RULE2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps_ff <= gst_pkg::PS_RESET;
    end else if (clear) begin
      ps_ff <= gst_pkg::PS_RESET; // see RULE3
    end else if (edge_in) begin
      ps_ff <= tick ? gst_pkg::PS_RESET : nxt_ps; // see RULE1
    end
  end

endmodule

// >>> rtl/gst_timer.sv
// Gated sixteen-bit timer with prescaler, gate and overflow flag.
`timescale 1ns/1ps
// Function
// RULE1: Prescaler divides by 1, 2, 4 or 8.
// RULE2: Prescale counter has no software access.
// RULE3: Count byte write clears the prescaler.
// RULE4: Oscillator enable starts oscillator, runs in Sleep.
// RULE5: Software waits 1024 cycles from FC00h preset.
// RULE6: Sync disable uses external clock unsynchronised.
// RULE7: Asynchronous external mode counts during Sleep.
// RULE8: Asynchronous overflow can wake the processor.
// RULE9: Mode switch may lose or add one increment.
// RULE10: Byte reads are valid while externally clocked.
// RULE11: Software handles overflow between byte reads.
// RULE12: Software stops counter before writing bytes.
// RULE13: Without gate mode the counter runs freely.
// RULE14: Gate enable and polarity bits configure gating.
// RULE15: Count when gate level equals polarity.
// RULE16: Inactive gate holds the count.
// RULE17: Gate source is selectable among several.
// RULE18: Wrap to zero sets sticky overflow flag.
// RULE19: Timer on bit starts and stops counting.
module gst_timer (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Control and gate settings.
  input  wire gst_pkg::gst_ctrl_t   ctrl,
  input  wire gst_pkg::gst_gate_t   gate_ctrl,
  // Software count access and flag clear.
  input  wire gst_pkg::gst_wr_t     wr,
  input  wire logic                 flag_clear,
  // Power state.
  input  wire logic                 sleep,
  // External clock, gate sources and crystal.
  input  wire logic                 count_clock,
  input  wire logic [3:0]           gate_input,
  input  wire logic                 crystal_in_pin,
  // Outputs.
  output logic                      crystal_out_pin,
  output logic                      osc_running,
  output logic [7:0]                count_low_byte,
  output logic [7:0]                count_high_byte,
  output logic                      overflow_flag,
  output logic                      wake
);

  // Count state, synchroniser, edge memories and output registers.
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic        ext_s1_ff;
  logic        ext_s2_ff;
  logic        ext_prev_ff;
  logic        ext_raw_prev_ff;
  logic        xtal_out_ff;
  logic        osc_on_ff;
  logic        flag_ff;
  logic        wake_ff;
  // Combinational decode terms.
  logic        ext_level;
  logic        ext_edge;
  logic        src_edge;
  logic        gate_level;
  logic        gate_open;
  logic        run;
  logic        tick;
  logic        ps_clear;
  logic        wrap_now;

  // A tick that leaves the all-ones count is the wrap event; the flag
  // and the wake request must agree on it, so both use this one test.
  function automatic logic wrap_event(input logic        t,
                                      input logic [15:0] c);
    return t && (c == gst_pkg::COUNT_ALL_ONES);
  endfunction

  // Only the unsynchronised external path keeps a clock in Sleep, so
  // only that mode may go on counting there.
  function automatic logic counts_asleep(input gst_pkg::gst_ctrl_t c);
    return c.sync_disable && (c.clk_src == gst_pkg::GST_SRC_EXT);
  endfunction

  // Two-stage synchroniser for the external count clock.
  // The first stage is read by nothing but the second.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
    end else begin
      ext_s1_ff <= count_clock;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // Pick the synchronised or direct external level.
  always_comb begin
    ext_level = ctrl.sync_disable ? count_clock : ext_s2_ff; // see RULE6
  end

  // Edge memories of the two external paths; a mode switch may miss
  // or double one edge since the paths lag differently.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_ff     <= 1'b0;
      ext_raw_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff     <= ext_s2_ff;
      ext_raw_prev_ff <= count_clock; // see RULE9
    end
  end

  // Rising edge of the chosen source.
  // Each path compares with its own previous sample.
  always_comb begin
    ext_edge = ctrl.sync_disable ? (ext_level && !ext_raw_prev_ff)
                                 : (ext_level && !ext_prev_ff);
    if (ctrl.clk_src == gst_pkg::GST_SRC_EXT) begin
      src_edge = ext_edge;
    end else begin
      src_edge = !sleep; // System clock stops in Sleep.
    end
  end

  // Gate source select, polarity match and run condition.
  always_comb begin
    gate_level = gate_input[gate_ctrl.gate_select]; // see RULE17
    // The gate is active when its level matches the polarity bit.
    gate_open  = (gate_level == gate_ctrl.gate_polarity); // see RULE15
    // Free running unless gated; holds while gate inactive.
    run = ctrl.timer_on && // see RULE19
          (!gate_ctrl.gate_enable || gate_open); // see RULE13 RULE14 RULE16
    // Sleep stops only synchronised counting.
    run = run && (!sleep || counts_asleep(ctrl)); // see RULE7
    ps_clear = wr.wr_low || wr.wr_high; // see RULE3
  end

  // Prescale divider; its count stays hidden inside the submodule.
  gst_prescaler u_prescaler (
    .clk             (clk),
    .rst_b           (rst_b),
    .prescale_select (ctrl.prescale_select),
    .clear           (ps_clear),
    .edge_in         (src_edge && run),
    .tick            (tick)
  );

  // Next count from software writes or a tick. A write wins over a tick
  // on the byte it names; the other byte may still take the increment,
  // which is why software should stop the timer before writing.
  always_comb begin
    nxt_count = count_ff;
    if (tick) begin
      nxt_count = 16'(count_ff + 16'h0001); // see RULE18
    end
    if (wr.wr_low) begin
      nxt_count[7:0] = wr.data;
    end
    if (wr.wr_high) begin
      nxt_count[15:8] = wr.data;
    end
  end

  // Counter register; outputs are whole-clock registers so reads
  // never see a half-updated value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= gst_pkg::COUNT_RESET;
    end else begin
      count_ff <= nxt_count; // see RULE10
    end
  end

  // Wrap of the count in this cycle.
  always_comb begin
    wrap_now = wrap_event(tick, count_ff); // see RULE18
  end

  // Sticky overflow flag; a wrap in the clearing cycle wins.
  // Software clears it with a one-cycle pulse on flag_clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= 1'b0;
    end else if (wrap_now) begin
      flag_ff <= 1'b1; // see RULE18
    end else if (flag_clear) begin
      flag_ff <= 1'b0;
    end
  end

  // Wake request while asleep and the flag is set; it is registered
  // so the output cannot glitch on the wrap edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= sleep && (flag_ff || wrap_now); // see RULE8
    end
  end

  // Crystal amplifier: inverts the input while enabled, Sleep or not.
  // The analog oscillator itself is modelled as a plain inverter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_out_ff <= 1'b0;
      osc_on_ff   <= 1'b0;
    end else begin
      xtal_out_ff <= ctrl.secondary_osc_enable && !crystal_in_pin; // see RULE4
      osc_on_ff   <= ctrl.secondary_osc_enable; // see RULE4
    end
  end

  // Output drive from registers.
  // Either byte read sees a whole-clock value, never a torn one.
  always_comb begin
    count_low_byte  = count_ff[7:0];
    count_high_byte = count_ff[15:8];
    overflow_flag   = flag_ff;
    wake            = wake_ff;
    crystal_out_pin = xtal_out_ff;
    osc_running     = osc_on_ff;
  end

endmodule

// >>> tb/gst_ext_clk.sv
// External count clock source model.
`timescale 1ns/1ps
module gst_ext_clk #(parameter int HALF = 40) (
  // Control.
  input  wire logic en,
  // Clock out.
  output logic      count_clock
);
  // Toggles only while enabled and rests low between bursts.
  initial begin
    count_clock = 1'b0;
    forever begin
      #(HALF);
      count_clock = en ? ~count_clock : 1'b0;
    end
  end
endmodule

// >>> tb/gst_timer_checker.sv
// Assertion checker for the gated sixteen-bit timer.
`timescale 1ns/1ps
module gst_timer_checker (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst_b,
  // Timer inputs.
  input wire gst_pkg::gst_ctrl_t ctrl,
  input wire gst_pkg::gst_gate_t gate_ctrl,
  input wire gst_pkg::gst_wr_t   wr,
  input wire logic               flag_clear,
  input wire logic               sleep,
  input wire logic [3:0]         gate_input,
  input wire logic               crystal_in_pin,
  // Timer outputs.
  input wire logic               crystal_out_pin,
  input wire logic               osc_running,
  input wire logic [7:0]         count_low_byte,
  input wire logic [7:0]         count_high_byte,
  input wire logic               overflow_flag,
  input wire logic               wake
);
  // Helper terms for the count and the run conditions.
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  wire no_wr = !wr.wr_low && !wr.wr_high;
  wire free = ctrl.timer_on && ctrl.clk_src == gst_pkg::GST_SRC_SYS
    && ctrl.prescale_select == 2'h0 && !gate_ctrl.gate_enable
    && !sleep && no_wr;
  wire gate_off = gate_ctrl.gate_enable && no_wr
    && gate_input[gate_ctrl.gate_select] != gate_ctrl.gate_polarity;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wrap;
    cnt == 16'hffff && no_wr ##1 cnt == 16'h0000;
  endsequence
  a_free_count: assert property (
    free[*3] |=> cnt == $past(cnt) + 16'h1)
    else $error("count did not step");
  a_off_holds: assert property (
    (!ctrl.timer_on && no_wr)[*2] |=> $stable(cnt))
    else $error("count moved while off");
  a_gate_holds: assert property (gate_off[*4] |=> $stable(cnt))
    else $error("count moved with gate closed");
  a_wrap_sets: assert property (s_wrap |-> overflow_flag)
    else $error("wrap left flag low");
  a_flag_sticky: assert property (
    overflow_flag && !flag_clear |=> overflow_flag)
    else $error("flag dropped");
  a_flag_clears: assert property (
    flag_clear && cnt != 16'hffff |=> !overflow_flag)
    else $error("flag not cleared");
  a_wake_asleep: assert property (
    (sleep && overflow_flag)[*2] |-> wake)
    else $error("no wake");
  a_osc_follows: assert property (
    1'b1 |=> osc_running == $past(ctrl.secondary_osc_enable))
    else $error("oscillator state wrong");
  a_xtal_inverts: assert property (
    ctrl.secondary_osc_enable[*2]
      |=> crystal_out_pin == !$past(crystal_in_pin))
    else $error("amplifier output wrong");
endmodule
bind gst_timer gst_timer_checker u_chk (.clk, .rst_b, .ctrl, .gate_ctrl, .wr,
  .flag_clear, .sleep, .gate_input, .crystal_in_pin, .crystal_out_pin,
  .osc_running, .count_low_byte, .count_high_byte, .overflow_flag, .wake);

// >>> tb/gst_timer_tb.sv
// Self-checking testbench for the gated sixteen-bit timer.
`timescale 1ns/1ps
module gst_timer_tb;
  logic               clk, rst_b, flag_clear, sleep, ext_en;
  logic               count_clock, xout, osc_on, flag, wake;
  logic [3:0]         gate_input;
  logic [7:0]         lo, hi;
  gst_pkg::gst_ctrl_t ctrl;
  gst_pkg::gst_gate_t gate_ctrl;
  gst_pkg::gst_wr_t   wr;
  int                 errors, samples_checked;
  gst_ext_clk u_src (.en(ext_en), .count_clock(count_clock));
  gst_timer u_dut (.clk(clk), .rst_b(rst_b), .ctrl(ctrl),
    .gate_ctrl(gate_ctrl), .wr(wr), .flag_clear(flag_clear),
    .sleep(sleep), .count_clock(count_clock),
    .gate_input(gate_input), .crystal_in_pin(count_clock),
    .crystal_out_pin(xout), .osc_running(osc_on), .count_low_byte(lo),
    .count_high_byte(hi), .overflow_flag(flag), .wake(wake));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rate(input int n, input logic [15:0] e);
    logic [15:0] c0;
    c0 = {hi, lo};
    tick(n);
    check({hi, lo} - c0 === e, "count rate wrong");
  endtask
  // Writes the low then the high byte; callers stop the timer first.
  task automatic load(input logic [15:0] v);
    wr = '{1'b1, 1'b0, v[7:0]};
    tick(1);
    wr = '{1'b0, 1'b1, v[15:8]};
    tick(1);
    wr = '0;
  endtask
  task automatic t_prescale();
    for (int p = 0; p < 4; p++) begin
      ctrl = '{1'b0, p[1:0], 1'b0, 1'b0, gst_pkg::GST_SRC_SYS};
      load(16'h0100);
      ctrl.timer_on = 1'b1;
      tick(2);
      rate(64, 16'(64 >> p));
    end
    ctrl.timer_on = 1'b0;
    tick(3);
    rate(20, 16'h0);
  endtask
  task automatic t_gate();
    ctrl = '{1'b1, 2'h0, 1'b0, 1'b0, gst_pkg::GST_SRC_SYS};
    for (int i = 0; i < 4; i++) begin
      gate_ctrl = '{1'b1, i[1], i[1:0]};
      gate_input = {4{~i[0]}} ^ (4'h1 << i);
      tick(5);
      rate(32, (i[0] == i[1]) ? 16'd32 : 16'd0);
    end
    gate_ctrl = '0;
    tick(3);
    rate(16, 16'd16);
  endtask
  task automatic t_wrap();
    ctrl.timer_on = 1'b0;
    load(16'hfc00);
    flag_clear = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    ctrl.timer_on = 1'b1;
    tick(1023);
    check(flag === 1'b0, "flag early");
    tick(1);
    check(flag === 1'b1, "flag missing");
    flag_clear = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    tick(1);
    check(flag === 1'b0, "flag stuck");
  endtask
  task automatic t_sleep();
    ctrl = '{1'b0, 2'h0, 1'b1, 1'b1, gst_pkg::GST_SRC_EXT};
    load(16'hfff0);
    ctrl.timer_on = 1'b1;
    ext_en = 1'b1;
    sleep = 1'b1;
    tick(8);
    check(osc_on === 1'b1, "oscillator idle");
    rate(80, 16'd10);
    tick(80);
    check(wake === 1'b1, "no wake");
    ctrl.sync_disable = 1'b0;
    tick(8);
    rate(80, 16'd0);
    sleep = 1'b0;
    tick(8);
    rate(80, 16'd10);
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    {flag_clear, sleep, ext_en} = 3'h0;
    {ctrl, gate_ctrl, wr, gate_input} = '0;
    tick(8);
    rst_b = 1'b1;
    tick(2);
    t_prescale();
    t_gate();
    t_wrap();
    t_sleep();
    wrap_up();
  end
endmodule
